/* core/fsb_pkg.sv */
/*
  shared constants and types for the flash security and boot swap gate.
  assumes a 10 MHz pclk and an APB master with 32-bit data.
*/
`default_nettype none
package fsb_pkg;
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] FSB_ADDR_CTRL = 8'h00;
  localparam logic [7:0] FSB_ADDR_CMD  = 8'h04;
  localparam logic [7:0] FSB_ADDR_ARG  = 8'h08;
  localparam logic [7:0] FSB_ADDR_STAT = 8'h0c;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int FSB_CTRL_ENTER_EXT  = 0;
  localparam int FSB_CTRL_ENTER_SELF = 1;
  localparam int FSB_CTRL_LEAVE      = 2;
  localparam int FSB_CTRL_SWAP_VAL   = 4;
  localparam int FSB_CTRL_SWAP_WR    = 5;

  // ----------------------------------------------------------------
  // reset values and boot cluster layout
  // ----------------------------------------------------------------
  localparam logic [3:0]  FSB_SEC_RST      = 4'h0;
  localparam logic [15:0] FSB_CLUSTER_SIZE = 16'h1000;
  localparam logic [15:0] FSB_CLUSTER1_LO  = 16'h1000;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int FSB_CLK_PERIOD_NS = 100;
  localparam int FSB_HOSC_STAB_NS  = 10000;
  localparam int FSB_HOSC_STAB_CYC =
    (FSB_HOSC_STAB_NS + FSB_CLK_PERIOD_NS - 1) / FSB_CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FSB_CMD_CHIP_ERASE,
    FSB_CMD_BLOCK_ERASE,
    FSB_CMD_WRITE,
    FSB_CMD_SEC_SET
  } fsb_cmd_t;

  typedef enum logic [1:0] {
    FSB_MODE_NORMAL,
    FSB_MODE_EXT,
    FSB_MODE_SELF
  } fsb_mode_t;

  typedef struct packed {
    logic boot0;
    logic wr;
    logic blk;
    logic chip;
  } fsb_sec_t;

  typedef struct packed {
    logic       valid;
    fsb_cmd_t   cmd;
    logic [15:0] addr;
    logic [7:0] data;
  } fsb_flash_req_t;
endpackage
`default_nettype wire

/* core/fsb_sync2.sv */
/*
  two flip-flop synchroniser for pin levels.
  assumes the input is a slow level from outside the pclk domain.
*/
`default_nettype none
module fsb_sync2
  import fsb_pkg::*;
#(
  parameter int W = 1
)(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_q <= '0;
      q      <= '0;
    end
    else
    begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule
`default_nettype wire

/* core/fsb_store.sv */
/*
  stored security and boot swap settings.
  assumes the nonvolatile copy is presented on nv_* and is captured in
  the first cycle after reset release; updates are mirrored back out.
*/
`default_nettype none
module fsb_store
  import fsb_pkg::*;
(
  input  wire logic     pclk,
  input  wire logic     presetn,
  input  wire fsb_sec_t nv_sec,
  input  wire logic     nv_swap,
  input  wire logic     set_valid,
  input  wire fsb_sec_t set_bits,
  input  wire logic     clr_blk_wr,
  input  wire logic     swap_wr,
  input  wire logic     swap_val,
  output fsb_sec_t      sec_q,
  output logic          swap_q,
  output logic          loaded_q
);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sec_q    <= FSB_SEC_RST;
      swap_q   <= 1'b0;
      loaded_q <= 1'b0;
    end
    else if (!loaded_q)
    begin
      sec_q    <= nv_sec;
      swap_q   <= nv_swap;
      loaded_q <= 1'b1;
    end
    else
    begin
      // settings accumulate except blk and wr, which clr_blk_wr clears; chip and boot0 never fall
      if (set_valid)
        sec_q <= sec_q | set_bits;
      else if (clr_blk_wr)
      begin
        sec_q.blk <= 1'b0;
        sec_q.wr  <= 1'b0;
      end
      if (swap_wr)
        swap_q <= swap_val;
    end
  end
endmodule
`default_nettype wire

/* core/fsb_gate.sv */
/*
  flash security gate with boot swap control, APB register slave.
  assumes the flash macro holds a request while valid and answers with
  a one-cycle done pulse; interrupt flags come from pclk logic.
*/
`default_nettype none
module fsb_gate
  import fsb_pkg::*;
#(
  parameter int STAB_CYC = FSB_HOSC_STAB_CYC
)(
  input  wire logic           pclk,
  input  wire logic           presetn,
  input  wire logic           psel,
  input  wire logic           penable,
  input  wire logic           pwrite,
  input  wire logic [7:0]     paddr,
  input  wire logic [31:0]    pwdata,
  output logic      [31:0]    prdata,
  output logic                pready,
  output logic                pslverr,
  input  wire logic           program_mode_pin,
  input  wire logic [7:0]     irq_request_flags_low0,
  input  wire logic [7:0]     irq_request_flags_high0,
  input  wire logic [7:0]     irq_request_flags_low1,
  input  wire logic [7:0]     irq_request_flags_high1,
  input  wire logic [7:0]     irq_mask_flags_low0,
  input  wire logic [7:0]     irq_mask_flags_high0,
  input  wire logic [7:0]     irq_mask_flags_low1,
  input  wire logic [7:0]     irq_mask_flags_high1,
  input  wire logic           cpu_on_hosc,
  output fsb_flash_req_t      flash_req,
  output logic                flash_abort,
  input  wire logic           flash_done,
  input  wire logic           flash_ok,
  input  wire fsb_sec_t       nv_sec,
  input  wire logic           nv_swap,
  output fsb_sec_t            nv_sec_out,
  output logic                nv_swap_out,
  output logic                boot_swap_map
);
  // ----------------------------------------------------------------
  // types and state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_STAB,
    ST_BUSY,
    ST_SUSP
  } fsb_state_t;

  typedef struct packed {
    fsb_state_t     st;
    fsb_mode_t      mode;
    fsb_sec_t       act;
    logic           map_done;
    logic           boot_map;
    fsb_cmd_t       cmd;
    logic [15:0]    addr;
    logic [7:0]     data;
    logic           ok;
    logic           fail;
    logic           stopped;
    logic [15:0]    stab;
    fsb_flash_req_t req;
    logic           abort;
    logic [31:0]    rdata;
    logic           ready;
    logic           err;
  } fsb_regs_t;

  fsb_regs_t s_q;
  fsb_regs_t s_d;

  logic     pin_s;
  fsb_sec_t st_sec;
  logic     st_swap;
  logic     st_loaded;
  logic     sec_set;
  fsb_sec_t sec_bits;
  logic     clr_bw;
  logic     swap_wr;
  logic     swap_val;
  logic     irq_pend;
  logic     wr_acc;
  logic     setup;

  // ----------------------------------------------------------------
  // pin synchroniser and stored settings
  // ----------------------------------------------------------------
  fsb_sync2 #(.W(1)) u_pin (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (program_mode_pin),
    .q       (pin_s)
  );

  fsb_store u_store (
    .pclk       (pclk),
    .presetn    (presetn),
    .nv_sec     (nv_sec),
    .nv_swap    (nv_swap),
    .set_valid  (sec_set),
    .set_bits   (sec_bits),
    .clr_blk_wr (clr_bw),
    .swap_wr    (swap_wr),
    .swap_val   (swap_val),
    .sec_q      (st_sec),
    .swap_q     (st_swap),
    .loaded_q   (st_loaded)
  );

  assign nv_sec_out  = st_sec;
  assign nv_swap_out = st_swap;

  // ----------------------------------------------------------------
  // permission check
  // ----------------------------------------------------------------
  function automatic logic allowed(fsb_mode_t m, fsb_sec_t a,
                                   fsb_cmd_t c, logic [15:0] ad);
    logic in_c0;
    logic r;
    in_c0 = (ad < FSB_CLUSTER_SIZE);
    r     = 1'b0;
    if (c == FSB_CMD_SEC_SET)
      r = (m != FSB_MODE_NORMAL);
    else if (m == FSB_MODE_EXT)
    begin
      case (c)
        FSB_CMD_CHIP_ERASE:
          r = !a.chip && !a.boot0;
        FSB_CMD_BLOCK_ERASE:
          r = !a.chip && !a.blk && !a.wr
              && !(a.boot0 && in_c0);
        default:
          r = !a.wr && !(a.boot0 && in_c0);
      endcase
    end
    else if (m == FSB_MODE_SELF)
    begin
      // chip/blk/wr locks do not apply here
      if (c == FSB_CMD_CHIP_ERASE)
        r = 1'b0;
      else
        r = !(a.boot0 && in_c0);
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // interrupt pending: unmasked requests only, global disable ignored
  // ----------------------------------------------------------------
  assign irq_pend =
    |({irq_request_flags_high1, irq_request_flags_low1,
       irq_request_flags_high0, irq_request_flags_low0} &
      ~{irq_mask_flags_high1, irq_mask_flags_low1,
        irq_mask_flags_high0, irq_mask_flags_low0});

  assign setup  = psel && !penable;
  assign wr_acc = psel && penable && s_q.ready && pwrite;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d      = s_q;
    sec_set  = 1'b0;
    sec_bits = s_q.data[3:0];
    clr_bw   = 1'b0;
    swap_wr  = 1'b0;
    swap_val = pwdata[FSB_CTRL_SWAP_VAL];
    s_d.abort     = 1'b0;
    s_d.ready     = 1'b0;
    s_d.err       = 1'b0;
    s_d.req.cmd   = s_q.cmd;
    s_d.req.addr  = s_q.addr;
    s_d.req.data  = s_q.data;

    // boot mapping is taken once from the stored flag after reset
    if (st_loaded && !s_q.map_done)
    begin
      s_d.map_done = 1'b1;
      s_d.boot_map = st_swap;
    end

    // apb setup: prepare answer for the access phase
    if (setup)
    begin
      s_d.ready = 1'b1;
      s_d.rdata = 32'h0000_0000;
      if (paddr == FSB_ADDR_CTRL)
        s_d.rdata = {26'h0, st_swap, 5'h0};
      else if (paddr == FSB_ADDR_ARG)
        s_d.rdata = {8'h00, s_q.data, s_q.addr};
      else if (paddr == FSB_ADDR_STAT)
        s_d.rdata = {13'h0, pin_s, s_q.boot_map, st_swap,
                     st_sec, s_q.act, 2'h0, s_q.mode,
                     s_q.stopped, s_q.fail, s_q.ok,
                     (s_q.st != ST_IDLE)};
      else if (paddr != FSB_ADDR_CMD)
        s_d.err = 1'b1;
      else if (pwrite && s_q.st != ST_IDLE)
        s_d.err = 1'b1;
    end

    // apb access: register writes
    if (wr_acc && !s_q.err)
    begin
      if (paddr == FSB_ADDR_CTRL)
      begin
        if (pwdata[FSB_CTRL_SWAP_WR])
          swap_wr = 1'b1;
        if (pwdata[FSB_CTRL_LEAVE])
          s_d.mode = FSB_MODE_NORMAL;
        else if (pwdata[FSB_CTRL_ENTER_EXT])
        begin
          s_d.mode = FSB_MODE_EXT;
          s_d.act  = st_sec;
        end
        else if (pwdata[FSB_CTRL_ENTER_SELF])
        begin
          s_d.mode = FSB_MODE_SELF;
          s_d.act  = st_sec;
          if (s_q.st == ST_SUSP)
          begin
            s_d.st      = cpu_on_hosc ? ST_BUSY : ST_STAB;
            s_d.stab    = 16'h0000;
            s_d.stopped = 1'b0;
          end
        end
      end
      else if (paddr == FSB_ADDR_ARG)
      begin
        s_d.addr = pwdata[15:0];
        s_d.data = pwdata[23:16];
      end
      else if (paddr == FSB_ADDR_CMD)
      begin
        s_d.cmd     = fsb_cmd_t'(pwdata[1:0]);
        s_d.ok      = 1'b0;
        s_d.fail    = 1'b0;
        s_d.stopped = 1'b0;
        if (!allowed(s_q.mode, s_q.act, fsb_cmd_t'(pwdata[1:0]),
                     s_q.addr) ||
            (s_q.mode == FSB_MODE_SELF && !pin_s))
          s_d.fail = 1'b1;
        else if (fsb_cmd_t'(pwdata[1:0]) == FSB_CMD_SEC_SET)
        begin
          sec_set = 1'b1;
          s_d.ok  = 1'b1;
        end
        else if (s_q.mode == FSB_MODE_SELF && !cpu_on_hosc)
        begin
          s_d.st   = ST_STAB;
          s_d.stab = 16'h0000;
        end
        else
          s_d.st = ST_BUSY;
      end
    end

    // operation sequencer
    case (s_q.st)
      ST_STAB:
      begin
        if (s_q.stab >= 16'(STAB_CYC - 1))
          s_d.st = ST_BUSY;
        else
          s_d.stab = s_q.stab + 16'h0001;
        if (irq_pend || !pin_s)
        begin
          s_d.st      = ST_SUSP;
          s_d.stopped = 1'b1;
        end
      end
      ST_BUSY:
      begin
        s_d.req.valid = 1'b1;
        if (flash_done)
        begin
          s_d.req.valid = 1'b0;
          s_d.st        = ST_IDLE;
          s_d.ok        = flash_ok;
          s_d.fail      = !flash_ok;
          if (flash_ok && s_q.cmd == FSB_CMD_CHIP_ERASE &&
              s_q.mode == FSB_MODE_EXT)
            clr_bw = 1'b1;
        end
        else if (s_q.mode == FSB_MODE_SELF && (irq_pend || !pin_s))
        begin
          s_d.req.valid = 1'b0;
          s_d.abort     = 1'b1;
          s_d.st        = ST_SUSP;
          s_d.stopped   = 1'b1;
        end
      end
      default:
        s_d.req.valid = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q          <= '0;
      s_q.st       <= ST_IDLE;
      s_q.mode     <= FSB_MODE_NORMAL;
      s_q.act      <= FSB_SEC_RST;
      s_q.cmd      <= FSB_CMD_CHIP_ERASE;
      s_q.req.cmd  <= FSB_CMD_CHIP_ERASE;
    end
    else
      s_q <= s_d;
  end

  assign prdata        = s_q.rdata;
  assign pready        = s_q.ready;
  assign pslverr       = s_q.err;
  assign flash_req     = s_q.req;
  assign flash_abort   = s_q.abort;
  assign boot_swap_map = s_q.boot_map;
endmodule
`default_nettype wire

/* dv/fsb_gate_sva.sv */
/*
  port checker for fsb_gate, bound to every instance.
  assumes one pclk domain with async active-low presetn.
*/
`default_nettype none
module fsb_gate_chk
  import fsb_pkg::*;
(
  input wire logic           pclk,
  input wire logic           presetn,
  input wire logic           psel,
  input wire logic           penable,
  input wire logic [7:0]     paddr,
  input wire logic           pready,
  input wire logic           pslverr,
  input wire fsb_flash_req_t flash_req,
  input wire logic           flash_abort,
  input wire logic           flash_done,
  input wire logic           nv_swap,
  input wire fsb_sec_t       nv_sec_out,
  input wire logic           boot_swap_map
);
  logic [1:0] age_q;
  // edges since reset release, saturating
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      age_q <= 2'h0;
    else if (age_q != 2'h3)
      age_q <= age_q + 2'h1;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ready_first_a: assert property (psel && !penable |=> pready)
    else $error("no ready in access cycle");
  ready_once_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  unmapped_err_a: assert property (
      psel && !penable && paddr > 8'h0c |=> pslverr && pready)
    else $error("unmapped access without error");
  chip_sticky_a: assert property (
      nv_sec_out.chip |=> nv_sec_out.chip)
    else $error("chip lock cleared");
  boot0_sticky_a: assert property (
      nv_sec_out.boot0 |=> nv_sec_out.boot0)
    else $error("boot0 lock cleared");
  // abort and the fall of valid leave the gate on the same edge
  req_hold_a: assert property (
      flash_req.valid && !flash_done |=> flash_req.valid || flash_abort)
    else $error("request dropped early");
  abort_drop_a: assert property (
      flash_abort |=> !flash_abort && !flash_req.valid)
    else $error("abort not a clean stop");
  map_load_a: assert property (
      age_q == 2'h2 |-> boot_swap_map == $past(nv_swap, 2))
    else $error("boot map not loaded from swap flag");
  map_stable_a: assert property (
      age_q == 2'h3 |-> $stable(boot_swap_map))
    else $error("boot map moved outside reset");
  done_c: cover property (flash_done);
  abort_c: cover property (flash_abort);
  slverr_c: cover property (pready && pslverr);
endmodule
bind fsb_gate fsb_gate_chk u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
  .pslverr(pslverr), .flash_req(flash_req), .flash_abort(flash_abort),
  .flash_done(flash_done), .nv_swap(nv_swap), .nv_sec_out(nv_sec_out),
  .boot_swap_map(boot_swap_map));
`default_nettype wire

/* dv/fsb_flash_model.sv */
/*
  behavioural flash macro answering fsb_gate requests.
  assumes valid is held until done or abort.
*/
`default_nettype none
module fsb_flash_model
  import fsb_pkg::*;
(
  input  wire logic           pclk,
  input  wire logic           presetn,
  input  wire fsb_flash_req_t flash_req,
  input  wire logic           flash_abort,
  input  wire logic [7:0]     lat,
  output logic                flash_done,
  output logic                flash_ok,
  output int                  ops
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt;
  // done comes lat+1 cycles after valid; ok toggles outside done
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt <= 8'h0;
      flash_done <= 1'b0;
      flash_ok <= 1'b0;
      ops <= 0;
    end
    else
    begin
      flash_done <= 1'b0;
      flash_ok <= ~flash_ok;
      if (!flash_req.valid || flash_abort || flash_done)
        cnt <= 8'h0;
      else if (cnt >= lat)
      begin
        flash_done <= 1'b1;
        flash_ok <= 1'b1;
        ops <= ops + 1;
      end
      else
        cnt <= cnt + 8'h1;
    end
  end
endmodule
`default_nettype wire

/* dv/tb.sv */
/*
  self-checking bench for fsb_gate with a flash model.
  assumes APB slave answers in the first access cycle.
*/
`default_nettype none
`define CHK(a, b) \
  begin \
    compares++; \
    if ((a) !== (b)) \
    begin \
      $display("[ERR] t=%0t got %h exp %h", $time, a, b); \
      num_errors++; \
    end \
  end
module tb;
  import fsb_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic           pclk = 1'b0, presetn = 1'b0, psel = 1'b0;
  logic           penable = 1'b0, pwrite = 1'b0, pin = 1'b1;
  logic           hosc = 1'b1, nv_swap = 1'b0;
  logic [7:0]     paddr = 8'h0, lat = 8'h2;
  logic [31:0]    pwdata = 32'h0, prdata, r;
  logic           pready, pslverr, err, flash_done, flash_ok;
  logic           flash_abort, map, swap_out;
  logic [7:0]     rq [4] = '{default: 8'h0};
  logic [7:0]     mk [4] = '{default: 8'h0};
  fsb_sec_t       nv_sec = FSB_SEC_RST, sec_out, sec_m, act_m;
  fsb_flash_req_t flash_req;
  fsb_mode_t      md = FSB_MODE_NORMAL;
  logic [15:0]    a;
  int             num_errors = 0, compares = 0, ops, n;
  always #50 pclk = ~pclk;
  fsb_gate #(.STAB_CYC(4)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .program_mode_pin(pin), .irq_request_flags_low0(rq[0]),
    .irq_request_flags_high0(rq[1]), .irq_request_flags_low1(rq[2]),
    .irq_request_flags_high1(rq[3]), .irq_mask_flags_low0(mk[0]),
    .irq_mask_flags_high0(mk[1]), .irq_mask_flags_low1(mk[2]),
    .irq_mask_flags_high1(mk[3]), .cpu_on_hosc(hosc),
    .flash_req(flash_req), .flash_abort(flash_abort),
    .flash_done(flash_done), .flash_ok(flash_ok), .nv_sec(nv_sec),
    .nv_swap(nv_swap), .nv_sec_out(sec_out), .nv_swap_out(swap_out),
    .boot_swap_map(map));
  fsb_flash_model u_flash (.pclk(pclk), .presetn(presetn),
    .flash_req(flash_req), .flash_abort(flash_abort), .lat(lat),
    .flash_done(flash_done), .flash_ok(flash_ok), .ops(ops));
  task summarize;
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 16);
    if (k == 16)
    begin
      num_errors++;
      summarize();
    end
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wait_idle;
    int k;
    k = 0;
    do
    begin
      apb(1'b0, FSB_ADDR_STAT, 32'h0);
      k++;
    end
    while (r[0] !== 1'b0 && k < 60);
    if (k == 60)
    begin
      num_errors++;
      summarize();
    end
  endtask
  function automatic logic allow(fsb_cmd_t c, logic [15:0] ad);
    if (md == FSB_MODE_NORMAL)
      return 1'b0;
    if (c == FSB_CMD_SEC_SET)
      return 1'b1;
    if (act_m.boot0 && (c == FSB_CMD_CHIP_ERASE || ad < FSB_CLUSTER1_LO))
      return 1'b0;
    if (c == FSB_CMD_CHIP_ERASE)
      return md == FSB_MODE_EXT && !act_m.chip;
    if (md == FSB_MODE_SELF)
      return 1'b1;
    if (c == FSB_CMD_BLOCK_ERASE)
      return !(act_m.chip || act_m.blk || act_m.wr);
    return !act_m.wr;
  endfunction
  task op(logic ent, fsb_mode_t m, fsb_cmd_t c, logic [15:0] ad,
          logic [3:0] d);
    logic e;
    int o;
    if (ent)
    begin
      apb(1'b1, FSB_ADDR_CTRL, 32'h4);
      apb(1'b1, FSB_ADDR_CTRL, m == FSB_MODE_EXT ? 32'h1 : 32'h2);
      md = m;
      act_m = sec_m;
    end
    e = allow(c, ad);
    o = ops;
    apb(1'b1, FSB_ADDR_ARG, {8'h0, 4'h0, d, ad});
    apb(1'b1, FSB_ADDR_CMD, {30'h0, c});
    wait_idle();
    `CHK(r[2:1], {~e, e})
    `CHK(r[5:4], md)
    `CHK(r[11:8], act_m)
    if (c != FSB_CMD_SEC_SET)
      `CHK(ops - o, int'(e))
    if (e && c == FSB_CMD_SEC_SET)
      sec_m = sec_m | d;
    if (e && c == FSB_CMD_CHIP_ERASE)
      sec_m = sec_m & 4'h9;
    `CHK(sec_out, sec_m)
  endtask
  task rst;
    @(posedge pclk);
    presetn <= 1'b0;
    nv_sec <= sec_out;
    nv_swap <= swap_out;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    md = FSB_MODE_NORMAL;
    // reset drops the latched settings until the next mode entry
    act_m = FSB_SEC_RST;
  endtask
  initial
  begin
    void'($urandom(32'h8fd2));
    sec_m = FSB_SEC_RST;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    for (int i = 0; i < 40; i++)
    begin
      lat <= 8'($urandom % 6);
      a = $urandom % 2 ? 16'h0fff + 16'($urandom % 2) : 16'($urandom);
      op(i == 0 || $urandom % 3 == 0, fsb_mode_t'(1 + $urandom % 2),
         fsb_cmd_t'(i % 10 == 9 ? 3 : $urandom % 3), a,
         4'h1 << ((i / 10 + 1) % 4));
    end
    $display("random ops done");
    hosc <= 1'b0;
    lat <= 8'd30;
    op(1'b1, FSB_MODE_SELF, FSB_CMD_SEC_SET, 16'h0, 4'h0);
    for (int g = 0; g < 4; g++)
    begin
      apb(1'b1, FSB_ADDR_ARG, 32'h3000);
      apb(1'b1, FSB_ADDR_CMD, 32'h2);
      n = 0;
      while (flash_req.valid !== 1'b1 && n < 20)
      begin
        @(posedge pclk);
        n++;
      end
      `CHK(flash_req.valid, 1'b1)
      `CHK(flash_req.addr, 16'h3000)
      `CHK(flash_req.cmd, FSB_CMD_WRITE)
      `CHK(n > 3, 1'b1)
      apb(1'b1, FSB_ADDR_CMD, 32'h2);
      `CHK(err, 1'b1)
      rq[g] <= 8'h1 << ($urandom % 8);
      n = 0;
      while (flash_abort !== 1'b1 && n < 20)
      begin
        @(posedge pclk);
        n++;
      end
      `CHK(flash_abort, 1'b1)
      rq[g] <= 8'h0;
      apb(1'b0, FSB_ADDR_STAT, 32'h0);
      `CHK(r[3], 1'b1)
      apb(1'b1, FSB_ADDR_CTRL, 32'h2);
      wait_idle();
      `CHK(r[2:1], 2'b01)
    end
    mk <= '{default: 8'hff};
    rq <= '{default: 8'hff};
    op(1'b0, md, FSB_CMD_WRITE, 16'h3000, 4'h0);
    mk <= '{default: 8'h0};
    rq <= '{default: 8'h0};
    hosc <= 1'b1;
    $display("irq stop done");
    // mode pin low in self mode: command must fail, flash untouched
    pin <= 1'b0;
    repeat (3) @(posedge pclk);
    n = ops;
    apb(1'b1, FSB_ADDR_CMD, 32'h2);
    wait_idle();
    `CHK(r[2:1], 2'b10)
    `CHK(ops - n, 0)
    pin <= 1'b1;
    repeat (3) @(posedge pclk);
    $display("pin low done");
    op(1'b0, md, FSB_CMD_WRITE, 16'h1000, 4'h0);
    apb(1'b1, FSB_ADDR_CTRL, 32'h30);
    apb(1'b0, FSB_ADDR_STAT, 32'h0);
    `CHK(r[17:16], 2'b01)
    `CHK(swap_out, 1'b1)
    rst();
    `CHK(map, 1'b1)
    `CHK(sec_out, sec_m)
    op(1'b0, md, FSB_CMD_WRITE, 16'h2000, 4'h0);
    apb(1'b0, 8'h40, 32'h0);
    `CHK(err, 1'b1)
    apb(1'b1, FSB_ADDR_CTRL, 32'h20);
    rst();
    `CHK(map, 1'b0)
    `CHK(swap_out, 1'b0)
    $display("swap done");
    summarize();
  end
endmodule
`default_nettype wire
